//--- common/pdtmr_params.svh
`ifndef PDTMR_PARAMS_SVH
`define PDTMR_PARAMS_SVH

// Register byte offsets (word index = offset / 4)
`define PDTMR_ADDR_W          12
`define PDTMR_OFF_LOAD        12'h400
`define PDTMR_OFF_COUNT       12'h404
`define PDTMR_OFF_CTRL        12'h408
`define PDTMR_OFF_ACK         12'h40C
`define PDTMR_OFF_RAW         12'h410
`define PDTMR_OFF_MASKED      12'h414
`define PDTMR_OFF_RELOAD      12'h418
`define PDTMR_OFF_CLOCK_PREDIVIDER      12'h41C
`define PDTMR_OFF_FREE        12'h420

// Control field positions
`define PDTMR_CTL_WIDE        1
`define PDTMR_CTL_DIV_LO      2
`define PDTMR_CTL_IE          5
`define PDTMR_CTL_EN          7
`define PDTMR_CTL_DBG         8
`define PDTMR_CTL_FREE_EN     9
`define PDTMR_CTL_FDIV_LO     16

// Reset values and control field mask
`define PDTMR_RST_FDIV        8'h3E
`define PDTMR_RST_CLOCK_PREDIVIDER      10'h07D
`define PDTMR_CTL_MASK        32'h00FF03AE

// Arbitrary neutral signature returned by a read of the acknowledge word
`define PDTMR_ACK_SIG         32'h5A5AC3C3

// Prescale terminal counts (ratio minus one)
`define PDTMR_PS16_TC         8'h0F
`define PDTMR_PS256_TC        8'hFF

`endif

//--- common/pdtmr_pkg.sv
package pdtmr_pkg;

    typedef enum logic [1:0] {
        PDTMR_BUS_IDLE,
        PDTMR_BUS_ANSWER
    } pdtmr_bus_t;

    typedef struct packed {
        logic [7:0] free_prescale;
        logic       free_enable;
        logic       stop_in_debug;
        logic       enable;
        logic       interrupt_enable;
        logic [1:0] prescale;
        logic       wide;
    } pdtmr_ctrl_t;

    typedef struct packed {
        pdtmr_bus_t  bus;
        logic [31:0] rdata;
        pdtmr_ctrl_t ctrl;
        logic [31:0] load_value;
        logic [31:0] count;
        logic [9:0]  clock_predivider;
        logic [9:0]  clock_predivider_cnt;
        logic [7:0]  ps_cnt;
        logic        pending;
        logic        irq;
        logic [31:0] free_count;
        logic [7:0]  free_div_cnt;
        logic        halt_s1;
        logic        halt_s2;
    } pdtmr_state_t;

endpackage

//--- tb/pdtmr_top_tb.sv
`timescale 1ns/1ps
`include "pdtmr_params.svh"
module pdtmr_top_tb;
    // ----------------------------------------
    // Stimulus and bookkeeping
    // ----------------------------------------
    logic        sys_clk;
    logic        rst_n;
    logic [11:0] avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        debug_halt;
    logic        timer_irq;
    logic [31:0] rd;
    logic [31:0] c1;
    logic [31:0] c2;
    int          fails;
    int          total_checks;

    pdtmr_top i_dut (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (4'hF),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .debug_halt      (debug_halt),
        .timer_irq       (timer_irq)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic close_out;
        if (fails == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        total_checks++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            fails++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    // Entered right after a rising edge; leaves one idle cycle behind
    task automatic bus_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= w;
        avs_read      <= !w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, avs_waitrequest, 1'b0);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
        bus_xfer(1'b1, a, d);
    endtask

    task automatic bus_rd(input logic [11:0] a, input logic [31:0] exp);
        bus_xfer(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask

    // Plain read into rd, judged by the caller
    task automatic bus_get(input logic [11:0] a);
        bus_xfer(1'b0, a, 32'h00000000);
    endtask

    task automatic wait_irq;
        int n;
        for (n = 0; n < 60 && timer_irq !== 1'b1; n++) begin
            @(posedge sys_clk);
        end
        chk({31'h0, timer_irq}, 32'h00000001);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        bus_rd(`PDTMR_OFF_CTRL, 32'h003E0020);
        bus_rd(`PDTMR_OFF_CLOCK_PREDIVIDER, 32'h0000007D);
        bus_rd(`PDTMR_OFF_LOAD, 32'h00000000);
        bus_rd(`PDTMR_OFF_COUNT, 32'h00000000);
        bus_rd(`PDTMR_OFF_RAW, 32'h00000000);
        bus_rd(`PDTMR_OFF_MASKED, 32'h00000000);
        bus_rd(`PDTMR_OFF_FREE, 32'h00000000);
        bus_rd(`PDTMR_OFF_ACK, `PDTMR_ACK_SIG);
        bus_wr(12'h500, 32'hFFFFFFFF);
        bus_rd(12'h500, 32'h00000000);
    endtask

    task automatic t_load;
        bus_wr(`PDTMR_OFF_LOAD, 32'h12345678);
        bus_rd(`PDTMR_OFF_COUNT, 32'h00005678);
        bus_wr(`PDTMR_OFF_CTRL, 32'h00000022);
        bus_wr(`PDTMR_OFF_LOAD, 32'h12345678);
        bus_rd(`PDTMR_OFF_COUNT, 32'h12345678);
        bus_wr(`PDTMR_OFF_RELOAD, 32'h00000007);
        bus_rd(`PDTMR_OFF_COUNT, 32'h12345678);
        bus_rd(`PDTMR_OFF_LOAD, 32'h00000007);
        bus_rd(`PDTMR_OFF_RELOAD, 32'h00000007);
    endtask

    // Bus overhead adds a few steps at ratio 1, hence the wider upper bound
    task automatic t_prescale;
        int i;
        int pd;
        int code;
        int ratio;
        for (i = 0; i < 5; i++) begin
            pd    = (i == 4) ? 3 : 0;
            code  = (i == 4) ? 1 : i;
            ratio = (pd + 1) * ((code == 1) ? 16 : (code == 2) ? 256 : 1);
            bus_wr(`PDTMR_OFF_CLOCK_PREDIVIDER, 32'(pd));
            bus_wr(`PDTMR_OFF_LOAD, 32'h00100000);
            bus_wr(`PDTMR_OFF_CTRL, 32'h000000A2 | 32'(code << 2));
            repeat (10 * ratio) @(posedge sys_clk);
            bus_wr(`PDTMR_OFF_CTRL, 32'h00000022);
            bus_get(`PDTMR_OFF_COUNT);
            chk_rng(32'h00100000 - rd, 32'd9, 32'(11 + 8 / ratio));
            c1 = rd;
            repeat (20) @(posedge sys_clk);
            bus_rd(`PDTMR_OFF_COUNT, c1);
        end
        bus_wr(`PDTMR_OFF_CLOCK_PREDIVIDER, 32'h00000000);
    endtask

    task automatic t_irq;
        bus_wr(`PDTMR_OFF_LOAD, 32'h00000004);
        bus_wr(`PDTMR_OFF_CTRL, 32'h000000A2);
        wait_irq();
        bus_rd(`PDTMR_OFF_MASKED, 32'h00000001);
        bus_wr(`PDTMR_OFF_ACK, 32'h00000001);
        wait_irq();
        bus_wr(`PDTMR_OFF_CTRL, 32'h00000002);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, timer_irq}, 32'h00000000);
        bus_rd(`PDTMR_OFF_RAW, 32'h00000001);
        bus_rd(`PDTMR_OFF_MASKED, 32'h00000000);
        bus_rd(`PDTMR_OFF_ACK, `PDTMR_ACK_SIG);
        bus_rd(`PDTMR_OFF_RAW, 32'h00000001);
        bus_wr(`PDTMR_OFF_ACK, 32'h00000001);
        bus_rd(`PDTMR_OFF_RAW, 32'h00000000);
    endtask

    task automatic t_debug;
        bus_wr(`PDTMR_OFF_LOAD, 32'h00100000);
        bus_wr(`PDTMR_OFF_CTRL, 32'h000003A2);
        debug_halt <= 1'b1;
        repeat (10) @(posedge sys_clk);
        bus_get(`PDTMR_OFF_COUNT);
        c1 = rd;
        bus_get(`PDTMR_OFF_FREE);
        c2 = rd;
        repeat (30) @(posedge sys_clk);
        bus_rd(`PDTMR_OFF_COUNT, c1);
        bus_rd(`PDTMR_OFF_FREE, c2);
        bus_wr(`PDTMR_OFF_CTRL, 32'h000002A2);
        repeat (30) @(posedge sys_clk);
        bus_get(`PDTMR_OFF_COUNT);
        chk_rng(c1 - rd, 32'd30, 32'd45);
        debug_halt <= 1'b0;
    endtask

    task automatic t_free;
        bus_wr(`PDTMR_OFF_CTRL, 32'h00030202);
        bus_get(`PDTMR_OFF_FREE);
        c1 = rd;
        repeat (80) @(posedge sys_clk);
        bus_get(`PDTMR_OFF_FREE);
        chk_rng(rd - c1, 32'd20, 32'd23);
        bus_wr(`PDTMR_OFF_CTRL, 32'h00030002);
        bus_get(`PDTMR_OFF_FREE);
        c2 = rd;
        bus_wr(`PDTMR_OFF_FREE, 32'h00000000);
        repeat (40) @(posedge sys_clk);
        bus_rd(`PDTMR_OFF_FREE, c2);
    endtask

    // ----------------------------------------
    // Clock, reset, sequence, watchdog
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    initial begin
        fails         = 0;
        total_checks  = 0;
        rst_n         = 1'b0;
        avs_address   = 12'h000;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h00000000;
        debug_halt    = 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_load();
        t_prescale();
        t_irq();
        t_debug();
        t_free();
        close_out();
    end

    // Runs well past the roughly 4000 cycles the scenarios need
    initial begin
        #(40 * 30000);
        fails++;
        close_out();
    end
endmodule

//--- verilog/pdtmr_top.sv
`timescale 1ns/1ps
`include "pdtmr_params.svh"
// How it works
// - One timer, continuous periodic mode only
// - Load write copies value into count
// - Enabled count decrements, reloads at zero
// - Zero reach sets sticky pending flag
// - Prescale codes divide by 1,16,256,1
// - Control bit 1 selects 16/32 bit
// - Control bit 7 enables counting, reset 0
// - Interrupt enable bit 5, resets to 1
// - Bit 8 freezes timer in debug halt
// - Bit 9 enables free counter, reset 0
// - Free counter advances every N+1 clocks
// - Writing ack bit 0 clears pending
// - Ack read returns signature, no effect
// - Raw status shows pending flag directly
// - Interrupt equals pending AND enable
// - Reload write changes only stored value
// - Load and reload share one register
// - Timer clock is bus clock/(clock_predivider+1)
// - Free counter increments and wraps, read-only
// - Free counter also halts in debug
module pdtmr_top (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Avalon-MM slave
    input  wire logic [11:0] avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Processor debug halt, asynchronous
    input  wire logic        debug_halt,
    // Timer interrupt
    output logic             timer_irq
);

    pdtmr_pkg::pdtmr_state_t s_q;
    pdtmr_pkg::pdtmr_state_t s_d;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] ctrl_word(input pdtmr_pkg::pdtmr_ctrl_t c);
        logic [31:0] w;
        w = 32'h0;
        w[`PDTMR_CTL_WIDE]                    = c.wide;
        w[`PDTMR_CTL_DIV_LO +: 2]             = c.prescale;
        w[`PDTMR_CTL_IE]                      = c.interrupt_enable;
        w[`PDTMR_CTL_EN]                      = c.enable;
        w[`PDTMR_CTL_DBG]                     = c.stop_in_debug;
        w[`PDTMR_CTL_FREE_EN]                 = c.free_enable;
        w[`PDTMR_CTL_FDIV_LO +: 8]            = c.free_prescale;
        return w;
    endfunction

    // Count window: 16-bit mode masks the upper half
    function automatic logic [31:0] width_mask(input logic wide, input logic [31:0] v);
        return wide ? v : {16'h0, v[15:0]};
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic        halted;
    logic        tick;
    logic        step;
    logic        zero_hit;
    logic        ack_clear;
    logic        acc;
    logic [31:0] cw;
    logic [31:0] cur;
    logic [7:0]  ps_tc;

    always_comb begin
        s_d       = s_q;
        s_d.halt_s1 = debug_halt;
        s_d.halt_s2 = s_q.halt_s1;
        halted    = s_q.ctrl.stop_in_debug && s_q.halt_s2;
        tick      = 1'b0;
        step      = 1'b0;
        zero_hit  = 1'b0;
        ack_clear = 1'b0;
        acc       = 1'b0;
        cw        = 32'h0;
        cur       = width_mask(s_q.ctrl.wide, s_q.count);
        ps_tc     = 8'h00;

        if (s_q.ctrl.enable && !halted) begin
            if (s_q.clock_predivider_cnt >= s_q.clock_predivider) begin
                s_d.clock_predivider_cnt = 10'h000;
                tick           = 1'b1;
            end else begin
                s_d.clock_predivider_cnt = s_q.clock_predivider_cnt + 10'h001;
            end
        end

        case (s_q.ctrl.prescale)
            2'b01:   ps_tc = `PDTMR_PS16_TC;
            2'b10:   ps_tc = `PDTMR_PS256_TC;
            default: ps_tc = 8'h00;
        endcase
        if (tick) begin
            if (s_q.ps_cnt >= ps_tc) begin
                s_d.ps_cnt = 8'h00;
                step       = 1'b1;
            end else begin
                s_d.ps_cnt = s_q.ps_cnt + 8'h01;
            end
        end

        if (step) begin
            if (cur == 32'h0) begin
                s_d.count = width_mask(s_q.ctrl.wide, s_q.load_value);
                zero_hit  = 1'b1;
            end else begin
                s_d.count = cur - 32'h1;
            end
        end

        if (s_q.ctrl.free_enable && !halted) begin
            if (s_q.free_div_cnt >= s_q.ctrl.free_prescale) begin
                s_d.free_div_cnt = 8'h00;
                s_d.free_count   = s_q.free_count + 32'h1;
            end else begin
                s_d.free_div_cnt = s_q.free_div_cnt + 8'h01;
            end
        end

        // Bus slave: one wait cycle, answer on the second
        s_d.bus = pdtmr_pkg::PDTMR_BUS_IDLE;
        if ((avs_read || avs_write) && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE) begin
            s_d.bus = pdtmr_pkg::PDTMR_BUS_ANSWER;
        end
        acc = (avs_read || avs_write) && s_q.bus == pdtmr_pkg::PDTMR_BUS_ANSWER;

        if (acc && avs_write) begin
            case (avs_address)
                `PDTMR_OFF_LOAD: begin
                    cw             = be_merge(s_q.load_value, avs_writedata, avs_byteenable);
                    s_d.load_value = cw;
                    s_d.count      = width_mask(s_q.ctrl.wide, cw);
                end
                `PDTMR_OFF_RELOAD: begin
                    s_d.load_value = be_merge(s_q.load_value, avs_writedata, avs_byteenable);
                end
                `PDTMR_OFF_CTRL: begin
                    cw       = be_merge(ctrl_word(s_q.ctrl), avs_writedata, avs_byteenable);
                    s_d.ctrl.wide             = cw[`PDTMR_CTL_WIDE];
                    s_d.ctrl.prescale         = cw[`PDTMR_CTL_DIV_LO +: 2];
                    s_d.ctrl.interrupt_enable = cw[`PDTMR_CTL_IE];
                    s_d.ctrl.enable           = cw[`PDTMR_CTL_EN];
                    s_d.ctrl.stop_in_debug    = cw[`PDTMR_CTL_DBG];
                    s_d.ctrl.free_enable      = cw[`PDTMR_CTL_FREE_EN];
                    s_d.ctrl.free_prescale    = cw[`PDTMR_CTL_FDIV_LO +: 8];
                    // drop stale upper bits
                    // Switching to 16-bit mode must not leave a wide count behind
                    s_d.count                 = width_mask(cw[`PDTMR_CTL_WIDE], s_d.count);
                end
                `PDTMR_OFF_ACK: begin
                    ack_clear = avs_byteenable[0] && avs_writedata[0];
                end
                `PDTMR_OFF_CLOCK_PREDIVIDER: begin
                    cw         = be_merge({22'h0, s_q.clock_predivider}, avs_writedata, avs_byteenable);
                    s_d.clock_predivider = cw[9:0];
                end
                default: ;
            endcase
        end

        if (zero_hit) begin
            s_d.pending = 1'b1;
        end else if (ack_clear) begin
            s_d.pending = 1'b0;
        end
        s_d.irq = s_d.pending && s_d.ctrl.interrupt_enable;

        s_d.rdata = 32'h0;
        if (s_d.bus == pdtmr_pkg::PDTMR_BUS_ANSWER && avs_read) begin
            case (avs_address)
                `PDTMR_OFF_LOAD:   s_d.rdata = s_q.load_value;
                `PDTMR_OFF_RELOAD: s_d.rdata = s_q.load_value;
                `PDTMR_OFF_COUNT:  s_d.rdata = width_mask(s_q.ctrl.wide, s_q.count);
                `PDTMR_OFF_CTRL:   s_d.rdata = ctrl_word(s_q.ctrl);
                `PDTMR_OFF_ACK:    s_d.rdata = `PDTMR_ACK_SIG;
                `PDTMR_OFF_RAW:    s_d.rdata = {31'h0, s_q.pending};
                `PDTMR_OFF_MASKED: s_d.rdata = {31'h0, s_q.irq};
                `PDTMR_OFF_CLOCK_PREDIVIDER: s_d.rdata = {22'h0, s_q.clock_predivider};
                `PDTMR_OFF_FREE:   s_d.rdata = s_q.free_count;
                default:           s_d.rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s_q                       <= '0;
            s_q.ctrl.interrupt_enable <= 1'b1;
            s_q.ctrl.free_prescale    <= `PDTMR_RST_FDIV;
            s_q.clock_predivider                <= `PDTMR_RST_CLOCK_PREDIVIDER;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.rdata;
    assign avs_waitrequest = !(s_q.bus == pdtmr_pkg::PDTMR_BUS_ANSWER);
    assign timer_irq       = s_q.irq;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    chk_irq_and_mask: assert property (timer_irq == (s_q.pending && s_q.ctrl.interrupt_enable))
        else $error("irq not pending AND enable");
    chk_zero_sets_pend: assert property (zero_hit |=> s_q.pending)
        else $error("zero crossing did not set pending");
    chk_ack_set_wins: assert property (zero_hit && ack_clear |=> s_q.pending)
        else $error("ack beat zero crossing");
    chk_ack_clears: assert property (ack_clear && !zero_hit |=> !s_q.pending)
        else $error("ack did not clear pending");
    chk_pend_sticky: assert property (s_q.pending && !ack_clear |=> s_q.pending)
        else $error("pending dropped without ack");
    chk_disabled_hold: assert property (!s_q.ctrl.enable && !(acc && avs_write) |=> $stable(s_q.count))
        else $error("count moved while disabled");
    chk_load_copies: assert property (acc && avs_write && avs_address == `PDTMR_OFF_LOAD
                                      && avs_byteenable == 4'hF && s_q.ctrl.wide
                                      |=> s_q.count == $past(avs_writedata))
        else $error("load write not copied to count");
    chk_reload_keeps: assert property (acc && avs_write && avs_address == `PDTMR_OFF_RELOAD && !step
                                       |=> s_q.count == $past(s_q.count))
        else $error("reload write disturbed count");
    chk_narrow_upper: assert property (!s_q.ctrl.wide && $past(!s_q.ctrl.wide) |-> s_q.count[31:16] == 16'h0)
        else $error("upper count bits set in 16-bit mode");
    chk_debug_freeze: assert property (halted |=> $stable(s_q.free_count))
        else $error("free counter moved in debug halt");
    chk_step_decrement: assert property (step && cur != 32'h0 |=> s_q.count == $past(cur) - 32'h1
                                         || $past(acc && avs_write))
        else $error("count did not decrement on step");

    // ----------------------------------------
    // Count path checks
    // ----------------------------------------
    chk_zero_reload: assert property (zero_hit && !(acc && avs_write)
                                      |=> s_q.count == width_mask($past(s_q.ctrl.wide), $past(s_q.load_value)))
        else $error("zero crossing did not reload count");

    chk_no_step_off: assert property (!s_q.ctrl.enable |-> !step)
        else $error("step while timer disabled");

    chk_freeze_timer: assert property (halted |-> !step)
        else $error("timer stepped in debug halt");

    chk_prescale_one: assert property (tick && (s_q.ctrl.prescale == 2'b00 || s_q.ctrl.prescale == 2'b11) |-> step)
        else $error("ratio one did not step on tick");

    // Prescale of sixteen counts whole ticks, so two steps never come back to back
    chk_prescale_gap: assert property (step && s_q.ctrl.prescale == 2'b01 && !(acc && avs_write) |=> !step)
        else $error("prescale sixteen stepped twice in a row");

    chk_clock_predivider_gap: assert property (tick && s_q.clock_predivider != 10'h000 && !(acc && avs_write) |=> !tick)
        else $error("pre-divider ticked twice in a row");

    // ----------------------------------------
    // Free counter checks
    // ----------------------------------------
    chk_free_off_hold: assert property (!s_q.ctrl.free_enable |=> $stable(s_q.free_count))
        else $error("free counter moved while disabled");

    chk_free_by_one: assert property (s_q.free_count == $past(s_q.free_count)
                                      || s_q.free_count == $past(s_q.free_count) + 32'h1)
        else $error("free counter jumped");

    chk_free_spacing: assert property (s_q.ctrl.free_enable && !halted && s_q.free_div_cnt < s_q.ctrl.free_prescale
                                       |=> $stable(s_q.free_count))
        else $error("free counter advanced early");

    // ----------------------------------------
    // Register read checks
    // ----------------------------------------
    chk_ack_read_sig: assert property (avs_read && avs_address == `PDTMR_OFF_ACK && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE
                                       |=> avs_readdata == `PDTMR_ACK_SIG)
        else $error("ack read lacks signature");

    chk_ack_read_pure: assert property (acc && avs_read && avs_address == `PDTMR_OFF_ACK && !zero_hit
                                        |=> s_q.pending == $past(s_q.pending))
        else $error("ack read changed pending");

    chk_raw_read: assert property (avs_read && avs_address == `PDTMR_OFF_RAW && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE
                                   |=> avs_readdata == {31'h0, $past(s_q.pending)})
        else $error("raw status differs from pending");

    chk_masked_read: assert property (avs_read && avs_address == `PDTMR_OFF_MASKED
                                      && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE
                                      |=> avs_readdata == {31'h0, $past(s_q.pending && s_q.ctrl.interrupt_enable)})
        else $error("masked status not pending AND enable");

    chk_irq_off: assert property (!s_q.ctrl.interrupt_enable |-> !timer_irq)
        else $error("irq raised with enable clear");

    chk_shared_read: assert property (avs_read && avs_address == `PDTMR_OFF_RELOAD && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE
                                      |=> avs_readdata == $past(s_q.load_value))
        else $error("reload read differs from load value");

    chk_narrow_read: assert property (avs_read && avs_address == `PDTMR_OFF_COUNT && !s_q.ctrl.wide
                                      && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE
                                      |=> avs_readdata[31:16] == 16'h0)
        else $error("upper count bits read in 16-bit mode");

    chk_clock_predivider_read: assert property (avs_read && avs_address == `PDTMR_OFF_CLOCK_PREDIVIDER && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE
                                      |=> avs_readdata == {22'h0, $past(s_q.clock_predivider)})
        else $error("pre-divider read mismatch");

    chk_free_read: assert property (avs_read && avs_address == `PDTMR_OFF_FREE && s_q.bus == pdtmr_pkg::PDTMR_BUS_IDLE
                                    |=> avs_readdata == $past(s_q.free_count))
        else $error("free counter read mismatch");

    // Bus answer lasts one cycle only
    chk_wait_one: assert property (s_q.bus == pdtmr_pkg::PDTMR_BUS_ANSWER |=> avs_waitrequest)
        else $error("waitrequest low for two cycles");

    cov_zero_hit:   cover property (zero_hit);
    cov_ack:        cover property (ack_clear && s_q.pending);
    cov_free_tick:  cover property (s_q.ctrl.free_enable && $changed(s_q.free_count));
    cov_sig_read:   cover property (acc && avs_read && avs_address == `PDTMR_OFF_ACK);

endmodule
